// *** rtl/rca_defines.svh ***
// register offsets, reset values, field positions and scaling for the channel control slice
`ifndef RCA_DEFINES_SVH
`define RCA_DEFINES_SVH

`define RCA_OFS_EQ_INDEX 8'h13
`define RCA_OFS_RATE_LOCK 8'h2F
`define RCA_OFS_EYE_PAT 8'h30
`define RCA_OFS_ADAPT 8'h31
`define RCA_OFS_EYE_ENABLE 8'h36
`define RCA_OFS_EYE_LIMIT 8'h76

`define RCA_RST_EQ_INDEX 8'h00
`define RCA_RST_RATE_LOCK 8'h06
`define RCA_RST_EYE_PAT 8'h00
`define RCA_RST_ADAPT 8'h20
`define RCA_RST_EYE_ENABLE 8'h00
`define RCA_RST_EYE_LIMIT 8'h11

`define RCA_BIT_EQ_TABLE_INDEX_OVERRIDE 3
`define RCA_BIT_FREQ_CHECK 2
`define RCA_BIT_FLD_DISABLE 1
`define RCA_BIT_ADAPT_TRIG 0
`define RCA_BIT_RANGE_ERR 5
`define RCA_BIT_EYE_ALARM 4
`define RCA_BIT_PAT_CLK 3
`define RCA_BIT_EYE_ENABLE 6

`define RCA_REF_MODE_DEFAULT 2'h3
`define RCA_LIMIT_SCALE 3

`endif

// *** rtl/rca_pkg.sv ***
// types shared by the channel control slice
package rca_pkg;

   typedef enum logic [1:0] {RCA_PRBS7, RCA_PRBS9, RCA_PRBS15, RCA_PRBS31} rca_pattern_e;
   typedef enum logic [1:0] {RCA_ADAPT_NONE, RCA_ADAPT_LIN, RCA_ADAPT_LIN_DFE_LIN, RCA_ADAPT_LOCK_DFE_EQ} rca_adapt_e;
   typedef enum logic [1:0] {RCA_MERIT_BAD, RCA_MERIT_HORIZ, RCA_MERIT_VERT, RCA_MERIT_BOTH} rca_merit_e;

   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } rca_req_s;

   typedef struct packed {
      logic [7:0] horizontal_eye_opening;
      logic [7:0] vertical_eye_opening;
      logic valid;
      logic rangeError;
   } rca_eye_s;

   typedef struct packed {
      logic [7:0] eqIndex;
      logic [7:0] rateLock;
      logic [7:0] eyePat;
      logic [7:0] adapt;
      logic [7:0] eyeEnable;
      logic [7:0] eyeLimit;
      logic [7:0] rdData;
      logic rdValid;
      logic adaptStart;
      logic [2:0] lockSync1;
      logic [2:0] lockSync2;
      logic lockDetected;
      logic fldEnable;
      logic [7:0] eqSetting;
      logic patternClkEnable;
      rca_pattern_e pattern;
      rca_adapt_e adaptMode;
      rca_merit_e merit;
      logic meritInvalid;
   } rca_state_s;

endpackage : rca_pkg

// *** rtl/rca_eq_table.sv ***
// 32-entry equalizer setting table with registered read data
`timescale 1ns/10ps
module rca_eq_table #(
   parameter int DEPTH = 32,
   parameter int WIDTH = 8
) (
   input wire logic clk, // register clock
   input wire logic wrEn, // table write strobe
   input wire logic [$clog2(DEPTH)-1:0] wrAddr, // table write entry
   input wire logic [WIDTH-1:0] wrData, // table write value
   input wire logic [$clog2(DEPTH)-1:0] rdAddr, // table read entry
   output logic [WIDTH-1:0] rdData // registered table value
);

   logic [WIDTH-1:0] mem [DEPTH];

   // no reset on the array: contents come from configuration load
   always_ff @(posedge clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end

endmodule : rca_eq_table

// *** rtl/rca_channel_ctrl.sv ***
// per-channel equalizer, lock qualifier, adaptation, pattern and eye alarm control registers
`timescale 1ns/10ps
`include "rca_defines.svh"
module rca_channel_ctrl
   import rca_pkg::*;
#(
   parameter int EQ_W = 8,
   parameter int TABLE_DEPTH = 32
) (
   // clock, reset and management access
   input wire logic clk, // register clock, 100 MHz
   input wire logic arst_n, // asynchronous reset, active low
   input wire rca_req_s req, // register access from the management bus engine
   output logic [7:0] rdData, // read data, valid with rdValid
   output logic rdValid, // one-cycle pulse, answer to a read
   // equalizer table load
   input wire logic tableWrEn, // equalizer table write strobe
   input wire logic [$clog2(TABLE_DEPTH)-1:0] tableWrAddr, // equalizer table entry
   input wire logic [EQ_W-1:0] tableWrData, // equalizer table value
   // channel status; the lock inputs arrive from other clocks
   input wire logic [EQ_W-1:0] adaptiveEq, // setting from the adaptation engine
   input wire logic [1:0] refMode, // reference clock mode
   input wire logic cdrLockRaw, // raw lock from the recovery loop, asynchronous
   input wire logic freqCheckPass, // frequency check result, asynchronous
   input wire logic fldLock, // frequency-lock detector result, asynchronous
   input wire rca_eye_s eye, // eye monitor results, same clock
   // channel controls, all registered
   output logic [EQ_W-1:0] eqSetting, // equalizer setting in use
   output logic lockDetected, // qualified lock
   output logic fldEnable, // frequency-lock detector enable
   output logic adaptStart, // one-cycle pulse, starts linear adaptation
   output logic patternClkEnable, // clock gate for generator and checker
   output rca_pattern_e pattern, // generated sequence
   output rca_adapt_e adaptMode, // adaptation mode
   output rca_merit_e merit, // equalizer figure of merit
   output logic meritInvalid, // merit field holds the invalid code
   output logic eyeAlarm // sticky eye-opening alarm
);

   ////////////////////////////////////////////////////////////////////////////////
   // register map of this slice
   // 0x13 [4:0] table entry used while the override is set, [7:5] stored only
   // 0x2F [7:6] rate, [5:4] sub-rate, [3] override, [2] freq check, [1] detector off, [0] trigger
   // 0x30 [7:6] stored, [5] range error, [4] eye alarm, [3] pattern clock, [2] stored, [1:0] pattern
   // 0x31 [7] stored, [6:5] adaptation mode, [4:3] merit, [2:0] stored
   // 0x36 [6] eye alarm enable, the other bits stored only
   // 0x76 [7:4] horizontal limit, [3:0] vertical limit, eight counts a step

   localparam int IDX_W = $clog2(TABLE_DEPTH);

   rca_state_s st;
   rca_state_s next_st;
   logic [EQ_W-1:0] tableData;
   logic [7:0] heoLimit;
   logic [7:0] veoLimit;
   logic eyeLow;
   logic alarmRead;
   logic cdrOk;
   logic freqOk;
   logic fldOk;

   // registered table read: an index change reaches eqSetting two clocks later
   rca_eq_table #(
      .DEPTH(TABLE_DEPTH),
      .WIDTH(EQ_W)
   ) rca_eq_table_i (
      .clk(clk),
      .wrEn(tableWrEn),
      .wrAddr(tableWrAddr),
      .wrData(tableWrData),
      .rdAddr(st.eqIndex[IDX_W-1:0]),
      .rdData(tableData)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // limits are nibbles, each step worth eight counts of opening
   assign heoLimit = {4'h0, st.eyeLimit[7:4]} << `RCA_LIMIT_SCALE;
   assign veoLimit = {4'h0, st.eyeLimit[3:0]} << `RCA_LIMIT_SCALE;
   assign eyeLow = (eye.horizontal_eye_opening < heoLimit) || (eye.vertical_eye_opening < veoLimit);
   // a read of the alarm register drops the sticky flag
   assign alarmRead = req.rdEn && (req.addr == `RCA_OFS_EYE_PAT);

   // lock qualifiers: frequency and detector ones true when their check is off or has passed, loop lock only when it has passed
   assign cdrOk = st.lockSync2[0];
   assign freqOk = !st.rateLock[`RCA_BIT_FREQ_CHECK] || st.lockSync2[1];
   assign fldOk = !st.fldEnable || st.lockSync2[2];

   always_comb begin
      next_st = st;
      next_st.rdValid = 1'b0;
      // self-clear on the same edge that issues the start; a fresh write wins
      next_st.adaptStart = st.rateLock[`RCA_BIT_ADAPT_TRIG];
      if (st.rateLock[`RCA_BIT_ADAPT_TRIG]) begin
         next_st.rateLock[`RCA_BIT_ADAPT_TRIG] = 1'b0;
      end
      if (alarmRead) begin
         next_st.eyePat[`RCA_BIT_EYE_ALARM] = 1'b0;
      end

      // register writes; reserved bits are stored and steer nothing
      if (req.wrEn) begin
         if (req.addr == `RCA_OFS_EQ_INDEX) begin
            next_st.eqIndex = req.wrData;
         end else if (req.addr == `RCA_OFS_RATE_LOCK) begin
            next_st.rateLock = req.wrData;
         end else if (req.addr == `RCA_OFS_EYE_PAT) begin
            // status bits 5:4 are read-only; reserved bits are stored only
            next_st.eyePat = {req.wrData[7:6], st.eyePat[5:4], req.wrData[3:0]};
            if (alarmRead) begin
               next_st.eyePat[`RCA_BIT_EYE_ALARM] = 1'b0;
            end
         end else if (req.addr == `RCA_OFS_ADAPT) begin
            next_st.adapt = req.wrData;
         end else if (req.addr == `RCA_OFS_EYE_ENABLE) begin
            next_st.eyeEnable = req.wrData;
         end else if (req.addr == `RCA_OFS_EYE_LIMIT) begin
            next_st.eyeLimit = req.wrData;
         end
      end

      // hardware set wins over the clearing read
      if (eye.valid && st.eyeEnable[`RCA_BIT_EYE_ENABLE] && eyeLow) begin
         next_st.eyePat[`RCA_BIT_EYE_ALARM] = 1'b1;
      end
      // range error mirrors the monitor every clock, no latching
      next_st.eyePat[`RCA_BIT_RANGE_ERR] = eye.rangeError;

      // read data registered; unmapped offsets read as zero
      if (req.rdEn) begin
         next_st.rdValid = 1'b1;
         if (req.addr == `RCA_OFS_EQ_INDEX) begin
            next_st.rdData = st.eqIndex;
         end else if (req.addr == `RCA_OFS_RATE_LOCK) begin
            next_st.rdData = st.rateLock;
         end else if (req.addr == `RCA_OFS_EYE_PAT) begin
            next_st.rdData = st.eyePat;
         end else if (req.addr == `RCA_OFS_ADAPT) begin
            next_st.rdData = st.adapt;
         end else if (req.addr == `RCA_OFS_EYE_ENABLE) begin
            next_st.rdData = st.eyeEnable;
         end else if (req.addr == `RCA_OFS_EYE_LIMIT) begin
            next_st.rdData = st.eyeLimit;
         end else begin
            next_st.rdData = 8'h00;
         end
      end

      ////////////////////////////////////////////////////////////////////////////////
      // two flops on each asynchronous lock input; only the second one is read
      next_st.lockSync1 = {fldLock, freqCheckPass, cdrLockRaw};
      next_st.lockSync2 = st.lockSync1;
      if (refMode == `RCA_REF_MODE_DEFAULT) begin
         next_st.fldEnable = !st.rateLock[`RCA_BIT_FLD_DISABLE];
      end else begin
         // outside the default reference mode the detector stays on
         next_st.fldEnable = 1'b1;
      end
      next_st.lockDetected = cdrOk && freqOk && fldOk;
      if (st.rateLock[`RCA_BIT_EQ_TABLE_INDEX_OVERRIDE]) begin
         next_st.eqSetting = tableData;
      end else begin
         next_st.eqSetting = adaptiveEq;
      end

      // decoded controls follow their register bits one clock later
      // toggling this enable is how software restarts generator and checker
      next_st.patternClkEnable = st.eyePat[`RCA_BIT_PAT_CLK];
      next_st.pattern = rca_pattern_e'(st.eyePat[1:0]);
      next_st.adaptMode = rca_adapt_e'(st.adapt[6:5]);
      next_st.merit = rca_merit_e'(st.adapt[4:3]);
      next_st.meritInvalid = (st.adapt[4:3] == 2'b00);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // reset loads the register defaults; decodes start at their reset codes, except fldEnable, which starts on
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
         st.eqIndex <= `RCA_RST_EQ_INDEX;
         st.rateLock <= `RCA_RST_RATE_LOCK;
         st.eyePat <= `RCA_RST_EYE_PAT;
         st.adapt <= `RCA_RST_ADAPT;
         st.eyeEnable <= `RCA_RST_EYE_ENABLE;
         st.eyeLimit <= `RCA_RST_EYE_LIMIT;
         st.fldEnable <= 1'b1;
         st.adaptMode <= RCA_ADAPT_LIN;
         st.meritInvalid <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // every output straight from a flop of the state
   assign rdData = st.rdData;
   assign rdValid = st.rdValid;
   assign eqSetting = st.eqSetting;
   assign lockDetected = st.lockDetected;
   assign fldEnable = st.fldEnable;
   assign adaptStart = st.adaptStart;
   assign patternClkEnable = st.patternClkEnable;
   assign pattern = st.pattern;
   assign adaptMode = st.adaptMode;
   assign merit = st.merit;
   assign meritInvalid = st.meritInvalid;
   assign eyeAlarm = st.eyePat[`RCA_BIT_EYE_ALARM];

endmodule : rca_channel_ctrl

// *** test/rca_channel_ctrl_assertions.sv ***
// port checks for the channel control slice
`timescale 1ns/10ps
module rca_channel_ctrl_assertions
   import rca_pkg::*;
(
   input wire logic clk, // clock
   input wire logic arst_n, // reset
   input wire rca_req_s req, // access
   input wire logic rdValid, // answer
   input wire logic [7:0] rdData, // read data
   input wire rca_eye_s eye, // eye
   input wire logic [1:0] refMode, // ref mode
   input wire logic eyeAlarm, // alarm
   input wire logic adaptStart, // pulse
   input wire logic fldEnable, // fld on
   input wire logic patternClkEnable, // gate
   input wire rca_pattern_e pattern, // pattern
   input wire rca_adapt_e adaptMode, // mode
   input wire rca_merit_e merit, // merit
   input wire logic meritInvalid // bad merit
);
////////////////////////////////////////
default clocking @(posedge clk); endclocking
default disable iff (!arst_n);
a_read_answer: assert property (req.rdEn |=> rdValid) else $error("no read answer");
a_unmapped_zero: assert property (req.rdEn && req.addr == 8'h55 |=> rdData == 8'h00)
   else $error("unmapped read");
a_trig_start: assert property (req.wrEn && req.addr == 8'h2F && req.wrData[0] |-> ##2 adaptStart)
   else $error("no adapt start");
a_start_single: assert property (adaptStart |=> !adaptStart) else $error("start too long");
a_pat_clk: assert property (req.wrEn && req.addr == 8'h30 |-> ##2 patternClkEnable == $past(req.wrData[3], 2))
   else $error("pattern clock");
a_pat_sel: assert property (req.wrEn && req.addr == 8'h30 |-> ##2 pattern == $past(req.wrData[1:0], 2))
   else $error("pattern select");
a_mode_sel: assert property (req.wrEn && req.addr == 8'h31 |-> ##2 adaptMode == $past(req.wrData[6:5], 2))
   else $error("adapt mode");
a_merit_bad: assert property (meritInvalid == (merit == RCA_MERIT_BAD)) else $error("merit flag");
a_fld_free: assert property ($past(refMode) != 2'h3 && $past(refMode, 2) != 2'h3 |-> fldEnable)
   else $error("fld enable");
a_alarm_cause: assert property ($rose(eyeAlarm) |-> $past(eye.valid)) else $error("alarm cause");
a_alarm_hold: assert property ($fell(eyeAlarm) |-> $past(req.rdEn) && $past(req.addr) == 8'h30)
   else $error("alarm drop");
endmodule : rca_channel_ctrl_assertions

// *** test/rca_channel_ctrl_tb.sv ***
// self-checking bench for the channel control slice
`timescale 1ns/10ps
module rca_channel_ctrl_tb;
   import rca_pkg::*;
   logic clk, arst_n, rdValid, tableWrEn, cdrLockRaw, freqCheckPass, fldLock, lockDetected, fldEnable;
   logic adaptStart, patternClkEnable, meritInvalid, eyeAlarm;
   logic [7:0] rdData, tableWrData, adaptiveEq, eqSetting, m;
   logic [4:0] tableWrAddr;
   logic [1:0] refMode;
   rca_req_s req;
   rca_eye_s eye;
   rca_pattern_e pattern;
   rca_adapt_e adaptMode;
   rca_merit_e merit;
   int errTotal = 0;
   int comparisons = 0;
   int cyc = 0;
   rca_channel_ctrl rca_channel_ctrl_i (.*);
   ////////////////////////////////////////
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, errTotal);
      if (errTotal == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wt
   task automatic chk(input logic [7:0] g, e, input string s);
      comparisons++;
      if (g !== e) begin
         errTotal++;
         $display("ERROR %0t %s got %h expected %h", $time, s, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk) req <= '{1'b1, 1'b0, a, d};
      @(posedge clk) req.wrEn <= 1'b0;
   endtask : wr
   // bounded wait on the answer pulse, then compare what it carried
   task automatic rc(input logic [7:0] a, e, input string s);
      int n = 0;
      @(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk) req.rdEn <= 1'b0;
      #1;
      while (rdValid !== 1'b1 && n < 4) begin
         wt(1);
         n++;
      end
      chk(rdValid, 1'b1, s);
      chk(rdData, e, s);
   endtask : rc
   task automatic pulse(input logic [7:0] h, v);
      @(posedge clk) eye <= '{h, v, 1'b1, 1'b0};
      @(posedge clk) eye.valid <= 1'b0;
   endtask : pulse
   ////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         errTotal++;
         tally_and_finish();
      end
   end
   initial begin
      {arst_n, tableWrEn, tableWrAddr, tableWrData, cdrLockRaw, freqCheckPass, fldLock} = '0;
      req = '0;
      eye = '0;
      adaptiveEq = 8'h3C;
      refMode = 2'h3;
      repeat (5) @(posedge clk);
      #1;
      chk(fldEnable, 1, "fld at reset");
      @(posedge clk) arst_n <= 1'b1;
      wt(1);
      chk(fldEnable, 0, "fld default off");
      chk(adaptMode, 1, "mode at reset");
      chk(patternClkEnable, 0, "gate at reset");
      rc(8'h2F, 8'h06, "rate reset");
      rc(8'h30, 8'h00, "eye reset");
      rc(8'h31, 8'h20, "adapt reset");
      rc(8'h55, 8'h00, "unmapped");
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         m = 8'h84 | (i[7:0] << 5) | (i[7:0] << 3);
         wr(8'h30, 8'hFC | i[7:0]);
         wr(8'h31, m);
         wt(2);
         chk(pattern, i[7:0], "pattern");
         chk(patternClkEnable, 1, "gate on");
         chk(adaptMode, i[7:0], "mode");
         chk(merit, i[7:0], "merit");
         chk(meritInvalid, i == 0, "merit bad");
         rc(8'h30, 8'hCC | i[7:0], "eye readback");
         rc(8'h31, m, "adapt readback");
      end
      wr(8'h30, 8'h00);
      wt(2);
      chk(patternClkEnable, 0, "gate off");
      $display("test fields done");
      @(posedge clk) {tableWrEn, tableWrAddr, tableWrData} <= {1'b1, 5'h05, 8'hA5};
      @(posedge clk) tableWrEn <= 1'b0;
      wt(3);
      chk(eqSetting, 8'h3C, "adaptive eq");
      wr(8'h13, 8'hE5);
      wr(8'h2F, 8'h0F);
      for (int k = 0; k < 6 && adaptStart !== 1'b1; k++) wt(1);
      chk(adaptStart, 1, "adapt start");
      rc(8'h2F, 8'h0E, "self clear");
      chk(eqSetting, 8'hA5, "table eq");
      $display("test trigger done");
      @(posedge clk) cdrLockRaw <= 1'b1;
      wt(6);
      chk(lockDetected, 0, "no freq pass");
      @(posedge clk) freqCheckPass <= 1'b1;
      wt(6);
      chk(lockDetected, 1, "freq pass");
      wr(8'h2F, 8'h0C);
      wt(6);
      chk(fldEnable, 1, "fld enabled");
      chk(lockDetected, 0, "fld unlocked");
      @(posedge clk) refMode <= 2'h0;
      wr(8'h2F, 8'h0E);
      wt(6);
      chk(fldEnable, 1, "fld other mode");
      @(posedge clk) fldLock <= 1'b1;
      wt(6);
      chk(lockDetected, 1, "fld locked");
      wr(8'h2F, 8'h08);
      @(posedge clk) freqCheckPass <= 1'b0;
      wt(6);
      chk(lockDetected, 1, "freq check off");
      $display("test lock done");
      wr(8'h36, 8'h40);
      pulse(8'h07, 8'h20);
      wt(2);
      chk(eyeAlarm, 1, "alarm set");
      wt(5);
      chk(eyeAlarm, 1, "alarm held");
      rc(8'h30, 8'h10, "alarm read");
      chk(eyeAlarm, 0, "read clear");
      pulse(8'h20, 8'h07);
      wt(2);
      chk(eyeAlarm, 1, "vertical low");
      // event and clearing read land on the same edge: the set must win
      fork
         pulse(8'h00, 8'h00);
         rc(8'h30, 8'h10, "set wins read");
      join
      chk(eyeAlarm, 1, "set wins");
      rc(8'h30, 8'h10, "clear after set");
      chk(eyeAlarm, 0, "cleared again");
      pulse(8'h08, 8'h08);
      wt(2);
      chk(eyeAlarm, 0, "at limit");
      wr(8'h36, 8'h00);
      pulse(8'h00, 8'h00);
      wt(2);
      chk(eyeAlarm, 0, "alarm off");
      @(posedge clk) eye.rangeError <= 1'b1;
      wt(2);
      rc(8'h30, 8'h20, "range error");
      $display("test eye done");
      tally_and_finish();
   end
endmodule : rca_channel_ctrl_tb
bind rca_channel_ctrl rca_channel_ctrl_assertions rca_channel_ctrl_assertions_i (.*);
